//--- rtl/power_state_sequencer.sv
// power-state sequencer: off, deep-sleep, sleep, wakeup and full power
module power_state_sequencer
	import pwr_seq_pkg::*;
#(
	parameter int BLOCKS = BLOCKS_DEF, // gated block count
	parameter int LOCK_HOLD = LOCK_HOLD_DEF, // stable lock cycles before full power
	parameter int RET_DEPTH = RET_DEPTH_DEF, // retention words
	parameter int RET_WIDTH = RET_WIDTH_DEF // retention word width
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic nrst, // external reset, active low
	input wire logic chip_power_up_pin, // chip power-up, low means off
	input wire logic boot_strap_pin_a, // strap pin a
	input wire logic boot_strap_pin_b, // strap pin b
	input wire logic boot_strap_pin_c, // strap pin c
	input wire wake_src_t wake_src, // wake events, level
	input wire logic sleep_req, // software asks for sleep
	input wire logic deep_sleep_req, // software asks for deep-sleep
	input wire logic xtal_stable, // crystal stable indication
	input wire logic pll_locked, // PLL lock indication
	input wire logic [BLOCKS-1:0] clk_ctrl, // per-block clock enables
	input wire logic wait_for_interrupt_instruction, // cpu waiting
	input wire logic ret_we, // retention write strobe
	input wire logic [$clog2(RET_DEPTH)-1:0] ret_addr, // retention address
	input wire logic [RET_WIDTH-1:0] ret_wdata, // retention write data
	output pwr_ctrl_t pwr_ctrl, // domain and analog enables
	output logic [BLOCKS-1:0] block_clk_en, // fast clock gates
	output logic cpu_clk_en, // processor clock gate
	output logic [STRAP_W-1:0] strap_value, // latched strap value
	output logic internal_reset_n, // internal reset, active low
	output pwr_state_t state, // current power state
	output logic [RET_WIDTH-1:0] ret_rdata // retention read data
);

	localparam int CNT_W = $clog2(LOCK_HOLD + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOCK_HOLD - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	logic rst_meta_r;
	logic rst_n_s;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_s <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state machine and lock counter
	pwr_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic from_off_r, from_off_nxt;
	logic locked;
	logic any_wake;

	assign locked = xtal_stable && pll_locked;
	assign any_wake = |wake_src;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = '0;
		from_off_nxt = from_off_r;
		if (!chip_power_up_pin) begin
			state_nxt = ST_OFF;
			from_off_nxt = 1'b0;
		end else begin
			unique case (state_r)
				ST_OFF: begin
					state_nxt = ST_WAKE;
					from_off_nxt = 1'b1;
				end
				ST_DEEP: begin
					if (wake_src.rtc_timer || wake_src.ext_irq) begin
						state_nxt = ST_WAKE;
					end
				end
				ST_SLEEP: begin
					if (any_wake) begin
						state_nxt = ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (locked) begin
						cnt_nxt = cnt_r + CNT_ONE;
						if (cnt_r == CNT_LAST) begin
							state_nxt = ST_ON;
							from_off_nxt = 1'b0;
							cnt_nxt = '0;
						end
					end
				end
				ST_ON: begin
					if (deep_sleep_req) begin
						state_nxt = ST_DEEP;
					end else if (sleep_req) begin
						state_nxt = ST_SLEEP;
					end
				end
				default: begin
					state_nxt = ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_r <= ST_OFF;
			cnt_r <= '0;
			from_off_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			from_off_r <= from_off_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs decoded from the next state
	pwr_ctrl_t pwr_ctrl_nxt;
	logic [BLOCKS-1:0] block_clk_en_nxt;
	logic cpu_clk_en_nxt;
	logic [STRAP_W-1:0] strap_nxt;
	logic int_rst_n_nxt;

	always_comb begin
		pwr_ctrl_nxt = PWR_CTRL_RST;
		pwr_ctrl_nxt.rtc_domain_en = (state_nxt != ST_OFF);
		pwr_ctrl_nxt.rtc_clk_en = (state_nxt != ST_OFF);
		pwr_ctrl_nxt.main_power_en = (state_nxt == ST_SLEEP) || (state_nxt == ST_WAKE)
			|| (state_nxt == ST_ON);
		pwr_ctrl_nxt.xtal_en = (state_nxt == ST_WAKE) || (state_nxt == ST_ON);
		pwr_ctrl_nxt.pll_en = (state_nxt == ST_WAKE) || (state_nxt == ST_ON);
		block_clk_en_nxt = (state_nxt == ST_ON) ? clk_ctrl : '0;
		cpu_clk_en_nxt = (state_nxt == ST_ON) && !wait_for_interrupt_instruction;
		strap_nxt = strap_value;
		if (state_nxt == ST_OFF) begin
			strap_nxt = STRAP_RST;
		end else if (state_r == ST_OFF) begin
			strap_nxt[STRAP_A_POS] = boot_strap_pin_a;
			strap_nxt[STRAP_B_POS] = boot_strap_pin_b;
			strap_nxt[STRAP_C_POS] = boot_strap_pin_c;
		end
		int_rst_n_nxt = (state_nxt == ST_ON) || (state_nxt == ST_SLEEP);
	end

	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			pwr_ctrl <= PWR_CTRL_RST;
			block_clk_en <= '0;
			cpu_clk_en <= 1'b0;
			strap_value <= STRAP_RST;
			internal_reset_n <= 1'b0;
			state <= ST_OFF;
		end else begin
			pwr_ctrl <= pwr_ctrl_nxt;
			block_clk_en <= block_clk_en_nxt;
			cpu_clk_en <= cpu_clk_en_nxt;
			strap_value <= strap_nxt;
			internal_reset_n <= int_rst_n_nxt;
			state <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// retention memory in the always-on domain
	logic [RET_WIDTH-1:0] ret_mem_r [RET_DEPTH];
	logic [RET_WIDTH-1:0] ret_mem_nxt [RET_DEPTH];
	logic [RET_WIDTH-1:0] ret_rdata_nxt;

	always_comb begin
		ret_mem_nxt = ret_mem_r;
		ret_rdata_nxt = '0;
		if (!chip_power_up_pin) begin
			for (int i = 0; i < RET_DEPTH; i++) begin
				ret_mem_nxt[i] = '0;
			end
		end else if (state_r == ST_ON) begin
			ret_rdata_nxt = ret_mem_r[ret_addr];
			if (ret_we) begin
				ret_mem_nxt[ret_addr] = ret_wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int i = 0; i < RET_DEPTH; i++) begin
				ret_mem_r[i] <= '0;
			end
			ret_rdata <= '0;
		end else begin
			ret_mem_r <= ret_mem_nxt;
			ret_rdata <= ret_rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n_s);

	sequence seq_on_entry;
		(state == ST_WAKE) ##1 (state == ST_ON);
	endsequence

	a_off_clears: assert property (!chip_power_up_pin |=> state == ST_OFF && strap_value == STRAP_RST
		&& !pwr_ctrl.rtc_domain_en && !internal_reset_n)
		else $error("power-up low did not force off");
	a_deep_power: assert property (state == ST_DEEP |-> pwr_ctrl.rtc_domain_en
		&& !pwr_ctrl.main_power_en && !pwr_ctrl.xtal_en)
		else $error("deep-sleep power enables wrong");
	a_rtc_clock: assert property ((state == ST_DEEP || state == ST_SLEEP) |-> pwr_ctrl.rtc_clk_en)
		else $error("always-on clock stopped in sleep");
	a_ret_hold: assert property (state == ST_DEEP && chip_power_up_pin
		|=> ret_mem_r[$past(ret_addr)] == $past(ret_mem_r[ret_addr]))
		else $error("retention word changed in deep-sleep");
	a_sleep_xtal: assert property (state == ST_SLEEP |-> !pwr_ctrl.xtal_en && !pwr_ctrl.pll_en)
		else $error("crystal on in sleep");
	a_sleep_wake: assert property (state == ST_SLEEP && any_wake && chip_power_up_pin
		|=> state == ST_WAKE)
		else $error("wake source ignored in sleep");
	a_wake_xtal: assert property (state == ST_WAKE |-> pwr_ctrl.xtal_en && pwr_ctrl.pll_en)
		else $error("crystal or PLL off in wakeup");
	a_on_via_wake: assert property (state == ST_ON && $past(state) != ST_ON
		|-> $past(state) == ST_WAKE)
		else $error("full power entered without wakeup");
	a_block_gate: assert property (block_clk_en != '0 |-> state == ST_ON
		&& (block_clk_en & ~$past(clk_ctrl)) == '0)
		else $error("fast clock sent to disabled block");
	a_cpu_gate: assert property (state_nxt == ST_ON && wait_for_interrupt_instruction
		|=> !cpu_clk_en && pwr_ctrl.main_power_en)
		else $error("cpu clock not gated in wait");
	a_strap_latch: assert property (state == ST_OFF && chip_power_up_pin
		|=> strap_value == {$past(boot_strap_pin_c), $past(boot_strap_pin_b),
		$past(boot_strap_pin_a)})
		else $error("strap value not latched");
	a_lock_wait: assert property (seq_on_entry |-> $past(cnt_r) == CNT_LAST && $past(locked))
		else $error("full power before stable lock");
	a_reset_order: assert property (state == ST_OFF && chip_power_up_pin
		|=> state == ST_WAKE && !internal_reset_n)
		else $error("reset released before wakeup");

endmodule // power_state_sequencer

//--- rtl/pwr_seq_pkg.sv
// constants, carrier types and state codes for the power-state sequencer
//
// Behaviour
// - power-up pin low forces off; always-on domain disabled, all registers cleared.
// - deep-sleep powers only the always-on domain; main power removed.
// - always-on clock keeps running in deep-sleep so its timer can wake.
// - retention memory in always-on domain keeps contents through deep-sleep.
// - sleep keeps the always-on domain and main power on; crystal oscillator off.
// - any of four wake sources moves sleep into wakeup.
// - entering wakeup enables crystal oscillator and PLLs.
// - wakeup is the only path from either sleep state into full power.
// - full power sends fast clock only to blocks enabled in clock control.
// - processor clock gated off during wait-for-interrupt; rest stays powered.
// - three strap pins latched into a 3-bit boot and host-timing value.
// - external reset is active low; logic held in reset while low.
package pwr_seq_pkg;

	localparam int STRAP_W = 3; // strap value width
	localparam int STRAP_A_POS = 0; // strap pin a bit
	localparam int STRAP_B_POS = 1; // strap pin b bit
	localparam int STRAP_C_POS = 2; // strap pin c bit
	localparam logic [STRAP_W-1:0] STRAP_RST = 3'h0; // strap value after clear
	localparam int LOCK_HOLD_DEF = 4; // cycles lock must stay stable
	localparam int BLOCKS_DEF = 8; // clock-gated blocks
	localparam int RET_DEPTH_DEF = 8; // retention words
	localparam int RET_WIDTH_DEF = 32; // retention word width

	// one-hot power states
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_DEEP = 5'h02,
		ST_SLEEP = 5'h04,
		ST_WAKE = 5'h08,
		ST_ON = 5'h10
	} pwr_state_t;

	// wake event sources
	typedef struct packed {
		logic mac; // radio MAC event
		logic host; // host request
		logic rtc_timer; // always-on timer expiry
		logic ext_irq; // external interrupt
	} wake_src_t;

	// analog and domain enables
	typedef struct packed {
		logic rtc_domain_en; // always-on domain powered
		logic rtc_clk_en; // always-on clock running
		logic main_power_en; // rest of chip powered
		logic xtal_en; // crystal oscillator enabled
		logic pll_en; // PLLs enabled
	} pwr_ctrl_t;

	localparam pwr_ctrl_t PWR_CTRL_RST = '{default: 1'b0}; // all off

endpackage

//--- bench/lock_model.sv
// crystal and PLL model: indications settle some cycles after enable
module lock_model #(
	parameter int LAT = 3 // enabled cycles before crystal stable
) (
	input wire logic clk_sys, // system clock
	input wire logic en, // crystal and PLL enabled
	output logic xtal_stable, // crystal stable
	output logic pll_locked // PLL locked
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// indications low at start
	initial begin
		xtal_stable = 1'b0;
		pll_locked = 1'b0;
	end
	// crystal rises after LAT enabled cycles, PLL one cycle later; both drop at once when disabled
	always @(posedge clk_sys) begin
		cnt <= en ? cnt + 1 : 0;
		xtal_stable <= en && cnt >= LAT - 1;
		pll_locked <= en && cnt >= LAT;
	end
endmodule // lock_model

//--- bench/tb.sv
// self-checking bench for the power-state sequencer
module tb
	import pwr_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 4;
	logic clk_sys, nrst, chip_power_up_pin, sleep_req, deep_sleep_req, ret_we;
	logic boot_strap_pin_a, boot_strap_pin_b, boot_strap_pin_c;
	logic wait_for_interrupt_instruction, xtal_stable, pll_locked, cpu_clk_en, internal_reset_n;
	wake_src_t wake_src;
	logic [7:0] clk_ctrl, block_clk_en;
	logic [2:0] ret_addr, strap_value, st;
	logic [31:0] ret_wdata, ret_rdata, d;
	pwr_ctrl_t pwr_ctrl;
	pwr_state_t state;
	int err_count, comparisons, n;

	power_state_sequencer #(.LOCK_HOLD(HOLD)) i_power_state_sequencer (.clk_sys, .nrst,
		.chip_power_up_pin, .boot_strap_pin_a, .boot_strap_pin_b, .boot_strap_pin_c,
		.wake_src, .sleep_req, .deep_sleep_req, .xtal_stable, .pll_locked, .clk_ctrl,
		.wait_for_interrupt_instruction, .ret_we, .ret_addr, .ret_wdata, .pwr_ctrl,
		.block_clk_en, .cpu_clk_en, .strap_value, .internal_reset_n, .state, .ret_rdata);
	lock_model i_lock_model (.clk_sys, .en(pwr_ctrl.xtal_en & pwr_ctrl.pll_en), .xtal_stable,
		.pll_locked);

	////////////////////////////////////////////////////////////////
	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// step past edges and let them settle
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	// bounded wait for a state, n holds cycles waited
	task automatic wait_st(input pwr_state_t s);
		n = 0;
		while (state !== s && n < 40) begin
			tick(1);
			n++;
		end
		chk(state, s);
	endtask
	// wait for both lock indications, then expect full power after the hold count
	task automatic wait_on;
		#1;
		n = 0;
		while (!(xtal_stable && pll_locked) && n < 40) begin
			tick(1);
			n++;
		end
		tick(HOLD - 1);
		chk(state, ST_WAKE);
		tick(1);
		chk(state, ST_ON);
	endtask
	// expected domain and analog enables for a state
	function automatic pwr_ctrl_t exp_ctrl(input pwr_state_t s);
		case (s)
			ST_OFF: return PWR_CTRL_RST;
			ST_DEEP: return 5'h18; // always-on domain and its clock only
			ST_SLEEP: return 5'h1C; // main logic kept, crystal and PLLs off
			default: return 5'h1F; // wakeup and full power run everything
		endcase
	endfunction
	task stop_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		err_count++;
		stop_test();
	end
	// main sequence
	initial begin
		{nrst, chip_power_up_pin, boot_strap_pin_a, boot_strap_pin_b, boot_strap_pin_c} = '0;
		{sleep_req, deep_sleep_req, wait_for_interrupt_instruction, ret_we} = '0;
		wake_src = '0;
		clk_ctrl = '0;
		ret_addr = '0;
		ret_wdata = '0;
		err_count = 0;
		comparisons = 0;
		void'($urandom(32'hD7A0));
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			chip_power_up_pin <= 1'b0;
			tick(3);
			chk({state, pwr_ctrl}, {ST_OFF, exp_ctrl(ST_OFF)});
			chk(ret_rdata, 32'h0);
			st = i == 0 ? 3'h7 : (i == 1 ? 3'h0 : 3'($urandom));
			@(posedge clk_sys);
			{boot_strap_pin_c, boot_strap_pin_b, boot_strap_pin_a} <= st;
			chip_power_up_pin <= 1'b1;
			wait_st(ST_WAKE);
			chk({strap_value, internal_reset_n}, {st, 1'b0});
			chk(pwr_ctrl, exp_ctrl(ST_WAKE));
			@(posedge clk_sys);
			{boot_strap_pin_c, boot_strap_pin_b, boot_strap_pin_a} <= ~st;
			wait_on();
			chk({internal_reset_n, strap_value}, {1'b1, st});
			@(posedge clk_sys);
			clk_ctrl <= 8'($urandom);
			wait_for_interrupt_instruction <= 1'b1;
			tick(2);
			chk(block_clk_en, clk_ctrl);
			chk({cpu_clk_en, pwr_ctrl.main_power_en}, 2'h1);
			d = $urandom;
			@(posedge clk_sys);
			wait_for_interrupt_instruction <= 1'b0;
			ret_addr <= 3'(i);
			ret_wdata <= d;
			ret_we <= 1'b1;
			@(posedge clk_sys);
			ret_we <= 1'b0;
			tick(2);
			chk(cpu_clk_en, 32'h1);
			chk(ret_rdata, d);
			if (i % 2 == 0) begin
				@(posedge clk_sys);
				sleep_req <= 1'b1;
				wait_st(ST_SLEEP);
				chk({pwr_ctrl.rtc_clk_en, pwr_ctrl.xtal_en, block_clk_en}, 10'h200);
				chk(pwr_ctrl, exp_ctrl(ST_SLEEP));
				@(posedge clk_sys);
				sleep_req <= 1'b0;
				wake_src <= 4'(4'h8 >> (i / 2));
			end else begin
				@(posedge clk_sys);
				deep_sleep_req <= 1'b1;
				wait_st(ST_DEEP);
				chk(pwr_ctrl, exp_ctrl(ST_DEEP));
				@(posedge clk_sys);
				deep_sleep_req <= 1'b0;
				wake_src <= 4'hC;
				tick(3);
				chk(state, ST_DEEP);
				@(posedge clk_sys);
				wake_src <= i == 1 ? 4'h2 : 4'h1;
			end
			wait_st(ST_WAKE);
			@(posedge clk_sys);
			wake_src <= '0;
			wait_on();
			tick(1);
			chk(ret_rdata, d);
			if (i == 3) begin
				@(posedge clk_sys);
				nrst <= 1'b0;
				#2;
				chk({state, internal_reset_n}, {ST_OFF, 1'b0});
				repeat (2) @(posedge clk_sys);
				nrst <= 1'b1;
			end
		end
		stop_test();
	end
endmodule // tb
